// ### include/pdc_pkg.sv
/*
  Shared constants and carrier types for the primary data cache block.
  Assumes a single core clock, a word-wide memory bus with per-word
  acknowledge, and a plain register port for configuration.
*/
package pdc_pkg;
  localparam int WAYS = 4;
  localparam int SETS = 64;
  localparam int WORDS = 8;
  localparam int TAG_W = 25;
  localparam int IDX_W = 6;
  localparam int WRD_W = 3;
  localparam int PA_W = 36;
  localparam int VA_LOW_W = 11;
  localparam int TAG_LSB = 11;
  localparam int IDX_LSB = 5;
  localparam int WRD_LSB = 2;
  localparam logic [1:0] CS_INV = 2'h0;
  localparam logic [1:0] CS_VAL = 2'h3;
  localparam logic [1:0] WAY0 = 2'h0;
  localparam logic [WRD_W-1:0] LAST_WORD = 3'h7;
  localparam logic [4:0] LINE_OFS = 5'h00;
  localparam logic [1:0] WORD_OFS = 2'h0;
  // Register port
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CFG_DOFF = 0;
  localparam int CFG_IOFF = 1;
  localparam logic [1:0] CFG_RST = 2'h0;

  typedef enum logic [2:0] {
    OP_IDX_STORE_TAG, OP_FILL, OP_HIT_INV, OP_IDX_WB_INV
  } pdc_op_t;
  typedef enum logic [1:0] {SRC_CPU, SRC_COP, SRC_IF} pdc_src_t;

  typedef struct packed {
    logic write;
    logic wt;
    logic walloc;
    logic [VA_LOW_W-1:0] va_low;
    logic [PA_W-1:0] pa;
    logic [31:0] wdata;
  } pdc_req_t;

  typedef struct packed {
    pdc_op_t code;
    logic [1:0] way;
    logic [VA_LOW_W-1:0] va_low;
    logic [PA_W-1:0] pa;
    logic lock;
    logic valid;
  } pdc_cop_t;

  typedef struct packed {
    logic req;
    logic we;
    logic burst;
    logic [PA_W-1:0] addr;
    logic [31:0] wdata;
  } pdc_mem_t;
endpackage

// ### rtl/pdc_cache.sv
/*
  Primary data cache with per-line lock and FIFO replacement, plus the
  bypass path for instruction fetches while the instruction cache is off.
  Assumes requesters hold their valid until pdc accepts (req_ready) and
  that the memory side acknowledges each word with mem_ack.
*/
`timescale 1ns/10ps
module pdc_cache (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cpu_req_valid,
  input wire pdc_pkg::pdc_req_t cpu_req,
  input wire logic cop_valid,
  input wire pdc_pkg::pdc_cop_t cop,
  input wire logic ifetch_valid,
  input wire logic [pdc_pkg::PA_W-1:0] ifetch_pa,
  output logic req_ready,
  output logic cpu_done,
  output logic [31:0] cpu_rdata,
  output logic cop_done,
  output logic ifetch_done,
  output logic [31:0] ifetch_rdata,
  output logic ifetch_to_icache,
  output pdc_pkg::pdc_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import pdc_pkg::*;

  typedef enum {ST_IDLE, ST_REFILL, ST_WBACK, ST_SGL} pdc_state_t;

  // ==========================================================
  // Storage
  // ==========================================================
  logic [TAG_W-1:0] tag_r [0:WAYS-1][0:SETS-1];
  logic lock_r [0:WAYS-1][0:SETS-1];
  logic mod_r [0:WAYS-1][0:SETS-1];
  logic [1:0] st_r [0:WAYS-1][0:SETS-1];
  logic [1:0] ptr_r [0:SETS-1];
  logic [31:0] data_r [0:WAYS-1][0:SETS-1][0:WORDS-1];
  logic [31:0] vbuf_r [0:WORDS-1];

  pdc_state_t state_r, state_nxt;
  pdc_src_t src_r, src_nxt;
  pdc_req_t cur_r, cur_nxt;
  pdc_mem_t mem_r, mem_nxt;
  logic [WRD_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] vic_r, vic_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [PA_W-1:0] vaddr_r, vaddr_nxt;
  logic wb_pend_r, wb_pend_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic hit_r, hit_nxt;
  logic [31:0] reg_rdata_r, reg_rdata_nxt;
  logic cpu_done_r, cpu_done_nxt;
  logic [31:0] cpu_rdata_r, cpu_rdata_nxt;
  logic cop_done_r, cop_done_nxt;
  logic if_done_r, if_done_nxt;
  logic [31:0] if_rdata_r, if_rdata_nxt;
  logic if_pass_r, if_pass_nxt;

  // Array write controls
  logic [WAYS-1:0] m_mask;
  logic m_tag_we, m_lock_we, m_lock, m_st_we, m_mod_we, m_mod;
  logic [TAG_W-1:0] m_tag;
  logic [1:0] m_st;
  logic [IDX_W-1:0] m_idx;
  logic [WAYS-1:0] d_mask;
  logic [IDX_W-1:0] d_idx;
  logic [WRD_W-1:0] d_word;
  logic [31:0] d_data;
  logic p_we;
  logic [IDX_W-1:0] p_idx;
  logic [1:0] p_val;
  logic vbuf_cp;
  logic [1:0] vbuf_way;
  logic [IDX_W-1:0] vbuf_idx;

  // Lookup
  logic [IDX_W-1:0] lk_idx;
  logic [TAG_W-1:0] lk_tag;
  logic [WRD_W-1:0] lk_word;
  logic [WAYS-1:0] hit, lv, inv;
  logic [1:0] first_hit, first_inv, vic;
  logic go_fill, finish;

  function automatic logic [1:0] next_ptr(input logic [1:0] p,
                                          input logic [WAYS-1:0] lkv);
    logic [1:0] c;
    next_ptr = WAY0;
    // Skip locked valid ways; way 0 can never be locked, so one exists
    for (int k = WAYS - 1; k >= 1; k--) begin
      c = p + 2'(k);
      if (!lkv[c])
        next_ptr = c;
    end
  endfunction

  function automatic pdc_mem_t sgl_mem(input logic [PA_W-1:0] pa,
                                       input logic we,
                                       input logic [31:0] wd);
    sgl_mem.req = 1'b1;
    sgl_mem.we = we;
    sgl_mem.burst = 1'b0;
    sgl_mem.addr = {pa[PA_W-1:WRD_LSB], WORD_OFS};
    sgl_mem.wdata = wd;
  endfunction

  function automatic pdc_mem_t burst_mem(input logic [PA_W-1:0] pa,
                                         input logic we,
                                         input logic [31:0] wd);
    burst_mem.req = 1'b1;
    burst_mem.we = we;
    burst_mem.burst = 1'b1;
    burst_mem.addr = {pa[PA_W-1:IDX_LSB], LINE_OFS};
    burst_mem.wdata = wd;
  endfunction

  // ==========================================================
  // Hit check and victim choice
  // ==========================================================
  always_comb begin
    // Busy states look at the set in flight, so lv matches the pointer
    lk_idx = (state_r != ST_IDLE) ? idx_r
           : cop_valid ? cop.va_low[IDX_LSB +: IDX_W]
           : cpu_req.va_low[IDX_LSB +: IDX_W];
    lk_tag = cop_valid ? cop.pa[TAG_LSB +: TAG_W]
                       : cpu_req.pa[TAG_LSB +: TAG_W];
    lk_word = cpu_req.va_low[WRD_LSB +: WRD_W];
    first_hit = WAY0;
    first_inv = WAY0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      hit[w] = (st_r[w][lk_idx] == CS_VAL) && (tag_r[w][lk_idx] == lk_tag);
      lv[w] = lock_r[w][lk_idx] && (st_r[w][lk_idx] == CS_VAL);
      inv[w] = (st_r[w][lk_idx] != CS_VAL);
      if (hit[w])
        first_hit = 2'(w);
      if (inv[w])
        first_inv = 2'(w);
    end
    // Invalid way first, else the pointer, never a locked valid line
    if (|inv)
      vic = first_inv;
    else if (lv[ptr_r[lk_idx]])
      vic = next_ptr(ptr_r[lk_idx], lv);
    else
      vic = ptr_r[lk_idx];
  end

  // ==========================================================
  // Control next-state
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    cur_nxt = cur_r;
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    vic_nxt = vic_r;
    idx_nxt = idx_r;
    vaddr_nxt = vaddr_r;
    wb_pend_nxt = wb_pend_r;
    cfg_nxt = cfg_r;
    hit_nxt = hit_r;
    cpu_rdata_nxt = cpu_rdata_r;
    if_rdata_nxt = if_rdata_r;
    cpu_done_nxt = 1'b0;
    cop_done_nxt = 1'b0;
    if_done_nxt = 1'b0;
    if_pass_nxt = 1'b0;
    reg_rdata_nxt = 32'h0;
    m_mask = '0;
    m_idx = lk_idx;
    m_tag_we = 1'b0;
    m_tag = lk_tag;
    m_lock_we = 1'b0;
    m_lock = 1'b0;
    m_st_we = 1'b0;
    m_st = CS_INV;
    m_mod_we = 1'b0;
    m_mod = 1'b0;
    d_mask = '0;
    d_idx = lk_idx;
    d_word = lk_word;
    d_data = cpu_req.wdata;
    p_we = 1'b0;
    p_idx = lk_idx;
    p_val = next_ptr(ptr_r[lk_idx], lv);
    vbuf_cp = 1'b0;
    vbuf_way = vic;
    vbuf_idx = lk_idx;
    go_fill = 1'b0;
    finish = 1'b0;

    if (reg_wr && reg_addr == REG_CFG)
      cfg_nxt = reg_wdata[1:0];
    if (reg_rd) begin
      case (reg_addr)
        REG_CFG: reg_rdata_nxt = {30'h0, cfg_r};
        REG_STAT: reg_rdata_nxt = {30'h0, hit_r, state_r != ST_IDLE};
        default: reg_rdata_nxt = 32'h0;
      endcase
    end

    case (state_r)
      ST_IDLE: begin
        if (cop_valid) begin
          // Maintenance ops act even while the cache is disabled
          src_nxt = SRC_COP;
          cur_nxt = '{write: 1'b0, wt: 1'b0, walloc: 1'b0,
                      va_low: cop.va_low, pa: cop.pa, wdata: 32'h0};
          idx_nxt = lk_idx;
          if (cop.code != OP_FILL)
            p_we = 1'b1;
          case (cop.code)
            OP_IDX_STORE_TAG: begin
              m_mask = WAYS'(1) << cop.way;
              m_tag_we = 1'b1;
              m_lock_we = 1'b1;
              m_lock = cop.lock && (cop.way != WAY0);
              m_st_we = 1'b1;
              m_st = cop.valid ? CS_VAL : CS_INV;
              m_mod_we = 1'b1;
              finish = 1'b1;
            end
            OP_HIT_INV: begin
              m_mask = hit;
              m_st_we = 1'b1;
              m_mod_we = 1'b1;
              finish = 1'b1;
            end
            OP_IDX_WB_INV: begin
              m_mask = WAYS'(1) << cop.way;
              m_st_we = 1'b1;
              m_mod_we = 1'b1;
              if (st_r[cop.way][lk_idx] == CS_VAL && mod_r[cop.way][lk_idx])
              begin
                vbuf_cp = 1'b1;
                vbuf_way = cop.way;
                vaddr_nxt = {tag_r[cop.way][lk_idx], lk_idx, LINE_OFS};
                cnt_nxt = '0;
                mem_nxt = burst_mem(vaddr_nxt, 1'b1, data_r[cop.way][lk_idx][0]);
                state_nxt = ST_WBACK;
              end else begin
                finish = 1'b1;
              end
            end
            OP_FILL: go_fill = 1'b1;
            default: finish = 1'b1;
          endcase
        end else if (cpu_req_valid) begin
          src_nxt = SRC_CPU;
          cur_nxt = cpu_req;
          idx_nxt = lk_idx;
          if (cfg_r[CFG_DOFF]) begin
            // Disabled: no lookup, no array change, no burst
            mem_nxt = sgl_mem(cpu_req.pa, cpu_req.write, cpu_req.wdata);
            state_nxt = ST_SGL;
          end else if (|hit) begin
            hit_nxt = 1'b1;
            if (!cpu_req.write) begin
              cpu_rdata_nxt = data_r[first_hit][lk_idx][lk_word];
              finish = 1'b1;
            end else begin
              d_mask = hit;
              if (!cpu_req.wt) begin
                m_mask = hit;
                m_mod_we = 1'b1;
                m_mod = 1'b1;
                finish = 1'b1;
              end else begin
                mem_nxt = sgl_mem(cpu_req.pa, 1'b1, cpu_req.wdata);
                state_nxt = ST_SGL;
              end
            end
          end else begin
            hit_nxt = 1'b0;
            if (cpu_req.write && cpu_req.wt && !cpu_req.walloc) begin
              mem_nxt = sgl_mem(cpu_req.pa, 1'b1, cpu_req.wdata);
              state_nxt = ST_SGL;
            end else begin
              go_fill = 1'b1;
            end
          end
        end else if (ifetch_valid) begin
          src_nxt = SRC_IF;
          if (cfg_r[CFG_IOFF]) begin
            cur_nxt.write = 1'b0;
            cur_nxt.pa = ifetch_pa;
            mem_nxt = sgl_mem(ifetch_pa, 1'b0, 32'h0);
            state_nxt = ST_SGL;
          end else begin
            if_pass_nxt = 1'b1;
          end
        end
      end

      ST_REFILL: begin
        if (mem_ack) begin
          d_mask = WAYS'(1) << vic_r;
          d_idx = idx_r;
          d_word = cnt_r;
          d_data = mem_rdata;
          if (cnt_r == cur_r.va_low[WRD_LSB +: WRD_W] && src_r == SRC_CPU) begin
            if (cur_r.write)
              d_data = cur_r.wdata;
            else
              cpu_rdata_nxt = mem_rdata;
          end
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == LAST_WORD) begin
            // Lock flag is left as is, so a locked line stays locked
            m_mask = WAYS'(1) << vic_r;
            m_idx = idx_r;
            m_tag_we = 1'b1;
            m_tag = cur_r.pa[TAG_LSB +: TAG_W];
            m_st_we = 1'b1;
            m_st = CS_VAL;
            m_mod_we = 1'b1;
            m_mod = cur_r.write && !cur_r.wt;
            p_we = 1'b1;
            p_idx = idx_r;
            // The line just filled counts if it stays locked
            p_val = next_ptr(ptr_r[idx_r],
                             lv | (WAYS'(lock_r[vic_r][idx_r]) << vic_r));
            mem_nxt.req = 1'b0;
            cnt_nxt = '0;
            if (wb_pend_r) begin
              mem_nxt = burst_mem(vaddr_r, 1'b1, vbuf_r[0]);
              state_nxt = ST_WBACK;
            end else if (cur_r.write && cur_r.wt) begin
              mem_nxt = sgl_mem(cur_r.pa, 1'b1, cur_r.wdata);
              state_nxt = ST_SGL;
            end else begin
              finish = 1'b1;
            end
          end
        end
      end

      ST_WBACK: begin
        if (mem_ack) begin
          cnt_nxt = cnt_r + 3'h1;
          mem_nxt.wdata = vbuf_r[cnt_nxt];
          if (cnt_r == LAST_WORD) begin
            mem_nxt.req = 1'b0;
            wb_pend_nxt = 1'b0;
            if (cur_r.write && cur_r.wt) begin
              mem_nxt = sgl_mem(cur_r.pa, 1'b1, cur_r.wdata);
              state_nxt = ST_SGL;
            end else begin
              finish = 1'b1;
            end
          end
        end
      end

      ST_SGL: begin
        if (mem_ack) begin
          mem_nxt.req = 1'b0;
          if (src_r == SRC_IF)
            if_rdata_nxt = mem_rdata;
          else if (!cur_r.write)
            cpu_rdata_nxt = mem_rdata;
          finish = 1'b1;
        end
      end

      default: state_nxt = ST_IDLE;
    endcase

    if (go_fill) begin
      vic_nxt = vic;
      cnt_nxt = '0;
      wb_pend_nxt = (st_r[vic][lk_idx] == CS_VAL) && mod_r[vic][lk_idx];
      vaddr_nxt = {tag_r[vic][lk_idx], lk_idx, LINE_OFS};
      // Dirty victim parked before the refill overwrites it
      vbuf_cp = wb_pend_nxt;
      mem_nxt = burst_mem(cur_nxt.pa, 1'b0, 32'h0);
      state_nxt = ST_REFILL;
    end

    if (finish) begin
      state_nxt = ST_IDLE;
      case (src_nxt)
        SRC_CPU: cpu_done_nxt = 1'b1;
        SRC_COP: cop_done_nxt = 1'b1;
        SRC_IF: if_done_nxt = 1'b1;
        default: cpu_done_nxt = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      src_r <= SRC_CPU;
      cur_r <= '0;
      mem_r <= '0;
      cnt_r <= '0;
      vic_r <= WAY0;
      idx_r <= '0;
      vaddr_r <= '0;
      wb_pend_r <= 1'b0;
      cfg_r <= CFG_RST;
      hit_r <= 1'b0;
      reg_rdata_r <= 32'h0;
      cpu_done_r <= 1'b0;
      cpu_rdata_r <= 32'h0;
      cop_done_r <= 1'b0;
      if_done_r <= 1'b0;
      if_rdata_r <= 32'h0;
      if_pass_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      cur_r <= cur_nxt;
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
      vic_r <= vic_nxt;
      idx_r <= idx_nxt;
      vaddr_r <= vaddr_nxt;
      wb_pend_r <= wb_pend_nxt;
      cfg_r <= cfg_nxt;
      hit_r <= hit_nxt;
      reg_rdata_r <= reg_rdata_nxt;
      cpu_done_r <= cpu_done_nxt;
      cpu_rdata_r <= cpu_rdata_nxt;
      cop_done_r <= cop_done_nxt;
      if_done_r <= if_done_nxt;
      if_rdata_r <= if_rdata_nxt;
      if_pass_r <= if_pass_nxt;
    end
  end

  // ==========================================================
  // Line state arrays; no coherency traffic ever touches them
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < SETS; s++) begin
        ptr_r[s] <= WAY0;
        for (int w = 0; w < WAYS; w++) begin
          lock_r[w][s] <= 1'b0;
          mod_r[w][s] <= 1'b0;
          st_r[w][s] <= CS_INV;
        end
      end
    end else begin
      if (p_we)
        ptr_r[p_idx] <= p_val;
      for (int w = 0; w < WAYS; w++) begin
        if (m_mask[w] && m_lock_we)
          lock_r[w][m_idx] <= m_lock;
        if (m_mask[w] && m_mod_we)
          mod_r[w][m_idx] <= m_mod;
        if (m_mask[w] && m_st_we)
          st_r[w][m_idx] <= m_st;
      end
    end
  end

  // Tags and data carry no reset; the state field guards them
  always_ff @(posedge sys_clk) begin
    for (int w = 0; w < WAYS; w++) begin
      if (m_mask[w] && m_tag_we)
        tag_r[w][m_idx] <= m_tag;
      if (d_mask[w])
        data_r[w][d_idx][d_word] <= d_data;
    end
    if (vbuf_cp) begin
      for (int k = 0; k < WORDS; k++)
        vbuf_r[k] <= data_r[vbuf_way][vbuf_idx][k];
    end
  end

  assign req_ready = (state_r == ST_IDLE);
  assign reg_rdata = reg_rdata_r;
  assign cpu_done = cpu_done_r;
  assign cpu_rdata = cpu_rdata_r;
  assign cop_done = cop_done_r;
  assign ifetch_done = if_done_r;
  assign ifetch_rdata = if_rdata_r;
  assign ifetch_to_icache = if_pass_r;
  assign mem_o = mem_r;
endmodule

// ### verif/pdc_cache_assertions.sv
/*
  Port-level checks for the primary data cache.
  Bound to pdc_cache; sees only its ports.
*/
`timescale 1ns/10ps
module pdc_cache_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cpu_req_valid,
  input wire logic cop_valid,
  input wire logic req_ready,
  input wire logic cpu_done,
  input wire logic cop_done,
  input wire logic ifetch_done,
  input wire logic ifetch_to_icache,
  input wire pdc_pkg::pdc_mem_t mem_o,
  input wire logic mem_ack
);
  import pdc_pkg::*;
  logic doff_r, doff_nxt, ioff_r, ioff_nxt, cop_r, cop_nxt;
  // ==========================================
  // Config mirror
  // Maintenance ops may burst even while off
  always_comb begin
    doff_nxt = doff_r;
    ioff_nxt = ioff_r;
    cop_nxt = cop_r & ~cop_done;
    if (reg_wr && reg_addr == REG_CFG) begin
      doff_nxt = reg_wdata[CFG_DOFF];
      ioff_nxt = reg_wdata[CFG_IOFF];
    end
    if (req_ready && cop_valid) begin
      cop_nxt = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      doff_r <= 1'b0;
      ioff_r <= 1'b0;
      cop_r <= 1'b0;
    end else begin
      doff_r <= doff_nxt;
      ioff_r <= ioff_nxt;
      cop_r <= cop_nxt;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_cpu_take;
    req_ready && cpu_req_valid && !cop_valid;
  endsequence
  sequence s_cop_take;
    req_ready && cop_valid;
  endsequence
  a_cpu_done_bound: assert property (
    s_cpu_take |-> ##[1:300] cpu_done) else $error("cpu request hung");
  a_cop_done_bound: assert property (
    s_cop_take |-> ##[1:300] cop_done) else $error("cache op hung");
  a_busy_not_ready: assert property (
    mem_o.req |-> !req_ready) else $error("ready during bus cycle");
  a_single_when_off: assert property (
    doff_r && !cop_r && mem_o.req |-> !mem_o.burst)
    else $error("burst while cache off");
  a_burst_aligned: assert property (
    mem_o.req && mem_o.burst |-> mem_o.addr[4:0] == LINE_OFS)
    else $error("burst not line aligned");
  a_word_aligned: assert property (
    mem_o.req |-> mem_o.addr[1:0] == WORD_OFS) else $error("unaligned");
  a_addr_held: assert property (
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr))
    else $error("bus request dropped early");
  a_fetch_single: assert property (
    ifetch_done |-> ioff_r && $past(mem_ack)) else $error("bad fetch");
  a_fetch_icache: assert property (
    ifetch_to_icache |-> !ioff_r) else $error("fetch to disabled cache");
endmodule
bind pdc_cache pdc_cache_assertions u_chk (.sys_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .cpu_req_valid, .cop_valid, .req_ready, .cpu_done,
  .cop_done, .ifetch_done, .ifetch_to_icache, .mem_o, .mem_ack);

// ### verif/pdc_cache_test.sv
/*
  Self-checking bench for the primary data cache.
  Assumes pdc_mem_model on the bus side and the bound checker.
*/
`timescale 1ns/10ps
module pdc_cache_test;
  import pdc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cpu_rdata, ifetch_rdata, mem_rdata;
  logic [31:0] wlast, d;
  logic reg_wr, reg_rd, cpu_req_valid, cop_valid, ifetch_valid, req_ready;
  logic cpu_done, cop_done, ifetch_done, ifetch_to_icache, mem_ack, slow;
  logic fdone;
  logic [35:0] ifetch_pa, wbase;
  pdc_req_t cpu_req;
  pdc_cop_t cop;
  pdc_mem_t mem_o;
  int errors, num_checks, rcnt, wcnt, rc, wc;
  assign fdone = ifetch_done | ifetch_to_icache;
  always #25 sys_clk = ~sys_clk;
  pdc_cache u_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_req_valid, .cpu_req, .cop_valid, .cop, .ifetch_valid,
    .ifetch_pa, .req_ready, .cpu_done, .cpu_rdata, .cop_done, .ifetch_done,
    .ifetch_rdata, .ifetch_to_icache, .mem_o, .mem_ack, .mem_rdata);
  pdc_mem_model u_mem (.sys_clk, .rst, .slow, .mem_o, .mem_ack,
    .mem_rdata, .rcnt, .wcnt, .wbase, .wlast);
  // ==========================================
  // Helpers
  function automatic logic [35:0] pa(input int t, input int i, input int w);
    return 36'(t) << 11 | 36'(i) << 5 | 36'(w) << 2;
  endfunction
  function automatic logic [35:0] ex(input logic [35:0] x);
    return {4'h0, x[31:0] ^ 32'h5A5A0000};
  endfunction
  task chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic await(ref logic s);
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      if (s === 1'b1) return;
    end
    chk(0, 1);
  endtask
  task reg_acc(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task cpu(input logic w, t, al, input logic [35:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    cpu_req <= '{w, t, al, a[10:0], a, v};
    cpu_req_valid <= 1'b1;
    await(req_ready);
    cpu_req_valid <= 1'b0;
    await(cpu_done);
    d = cpu_rdata;
  endtask
  task cop_op(input pdc_op_t c, input logic [1:0] w, input logic [35:0] a,
      input logic l);
    @(posedge sys_clk);
    cop <= '{c, w, a[10:0], a, l, 1'b0};
    cop_valid <= 1'b1;
    await(req_ready);
    cop_valid <= 1'b0;
    await(cop_done);
  endtask
  task fetch(input logic [35:0] a);
    @(posedge sys_clk);
    ifetch_pa <= a;
    ifetch_valid <= 1'b1;
    await(req_ready);
    ifetch_valid <= 1'b0;
    rc = rcnt;
    await(fdone);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Watchdog, over thirty times the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end
  // ==========================================
  // Tests
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, cpu_req_valid, cop_valid} = '0;
    {ifetch_valid, ifetch_pa, cpu_req, cop, slow} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(36'(req_ready), 1);
    reg_acc(0, 4'hC, 0);
    chk(d, 0);
    rc = rcnt;
    cpu(0, 0, 0, pa(1, 3, 5), 0);
    chk(d, ex(pa(1, 3, 5)));
    cpu(0, 0, 0, pa(1, 3, 5), 0);
    chk(36'(rcnt - rc), 8);
    chk(d, ex(pa(1, 3, 5)));
    reg_acc(0, REG_STAT, 0);
    chk(d, 2);
    $display("test miss_hit done");
    slow <= 1'b1;
    cpu(1, 0, 0, pa(10, 4, 2), 32'h1234ABCD);
    cpu(0, 0, 0, pa(10, 4, 2), 0);
    chk(d, 36'h01234ABCD);
    for (int t = 11; t < 14; t++) cpu(0, 0, 0, pa(t, 4, 0), 0);
    wc = wcnt;
    cpu(0, 0, 0, pa(14, 4, 0), 0);
    chk(36'(wcnt - wc), 8);
    chk(wbase, pa(10, 4, 0));
    chk(wlast, ex(pa(10, 4, 7)));
    slow <= 1'b0;
    $display("test victim done");
    cpu(0, 0, 0, pa(20, 6, 0), 0);
    cop_op(OP_IDX_STORE_TAG, 2'h1, pa(0, 6, 0), 1'b1);
    cop_op(OP_FILL, 2'h0, pa(21, 6, 0), 1'b0);
    for (int t = 22; t < 27; t++) cpu(0, 0, 0, pa(t, 6, 0), 0);
    rc = rcnt;
    wc = wcnt;
    cpu(1, 0, 0, pa(21, 6, 3), 32'h600D0001);
    cpu(0, 0, 0, pa(21, 6, 3), 0);
    chk(d, 36'h0600D0001);
    chk(36'(rcnt - rc + wcnt - wc), 0);
    wc = wcnt;
    cop_op(OP_IDX_WB_INV, 2'h1, pa(0, 6, 0), 1'b0);
    chk(36'(wcnt - wc), 8);
    chk(wbase, pa(21, 6, 0));
    cop_op(OP_HIT_INV, 2'h0, pa(26, 6, 0), 1'b0);
    rc = rcnt;
    cpu(0, 0, 0, pa(26, 6, 0), 0);
    chk(36'(rcnt - rc), 8);
    $display("test lock done");
    wc = wcnt;
    cpu(1, 1, 0, pa(1, 3, 5), 32'hCAFE0001);
    chk(wbase, pa(1, 3, 5));
    cpu(0, 0, 0, pa(1, 3, 5), 0);
    chk(d, 36'h0CAFE0001);
    cpu(1, 1, 0, pa(30, 8, 1), 32'h0BADF00D);
    chk(36'(wcnt - wc), 2);
    cpu(0, 0, 0, pa(30, 8, 1), 0);
    chk(d, ex(pa(30, 8, 1)));
    $display("test write_through done");
    reg_acc(1, REG_CFG, 32'h1);
    rc = rcnt;
    wc = wcnt;
    cpu(0, 0, 0, pa(1, 3, 5), 0);
    chk(d, ex(pa(1, 3, 5)));
    cpu(1, 0, 0, pa(1, 3, 5), 32'h00000077);
    chk(36'(rcnt - rc + wcnt - wc), 2);
    reg_acc(1, REG_CFG, 32'h0);
    cpu(0, 0, 0, pa(1, 3, 5), 0);
    chk(d, 36'h0CAFE0001);
    $display("test disable done");
    fetch(pa(2, 0, 1));
    chk({ifetch_done, ifetch_to_icache}, 1);
    reg_acc(1, REG_CFG, 32'h2);
    fetch(pa(2, 0, 1));
    chk({ifetch_done, ifetch_to_icache}, 2);
    chk(ifetch_rdata, ex(pa(2, 0, 1)));
    $display("test fetch done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    reg_acc(0, REG_CFG, 0);
    chk(d, 0);
    cpu(0, 0, 0, pa(21, 6, 3), 0);
    chk(36'(rcnt), 8);
    $display("test reset done");
    finish_test();
  end
endmodule

// ### verif/pdc_mem_model.sv
/*
  Behavioural memory behind the cache bus, fast or slow.
  Assumes requests held until each word is acknowledged.
*/
`timescale 1ns/10ps
module pdc_mem_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire pdc_pkg::pdc_mem_t mem_o,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output int rcnt,
  output int wcnt,
  output logic [35:0] wbase,
  output logic [31:0] wlast
);
  import pdc_pkg::*;
  int wait_c, beat, b;
  logic we_q;
  logic [35:0] a;
  // ==========================================
  // Responder
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {mem_ack, mem_rdata, wbase, wlast, we_q} = '0;
      {wait_c, beat, rcnt, wcnt} = '0;
    end else begin
      // Direction change restarts the beat count
      b = (mem_o.we !== we_q) ? 0 : beat;
      a = mem_o.addr + (mem_o.burst ? 36'(4 * b) : 36'h0);
      we_q <= mem_o.we;
      mem_ack <= 1'b0;
      // Idle data line toggles so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      beat <= b;
      if (!mem_o.req) begin
        beat <= 0;
        wait_c <= 0;
      end else if (!mem_ack && wait_c < (slow ? 3 : 0)) begin
        wait_c <= wait_c + 1;
      end else if (!mem_ack) begin
        wait_c <= 0;
        mem_ack <= 1'b1;
        beat <= b + 1;
        if (mem_o.we) begin
          wcnt <= wcnt + 1;
          wlast <= mem_o.wdata;
          if (b == 0) wbase <= a;
        end else begin
          rcnt <= rcnt + 1;
          mem_rdata <= a[31:0] ^ 32'h5A5A0000;
        end
      end
    end
  end
endmodule
